// ==== logic/pseocp_consts.svh ====
`ifndef PSEOCP_CONSTS_SVH
`define PSEOCP_CONSTS_SVH

// clock and timer base
`define PSEOCP_CLK_HZ         25000000
`define PSEOCP_TICK_US        100
`define PSEOCP_TICK_CYC       ((`PSEOCP_CLK_HZ / 1000000) * `PSEOCP_TICK_US)
`define PSEOCP_UP_RATIO       16
`define PSEOCP_START_MS       60
`define PSEOCP_START_TICKS    (`PSEOCP_START_MS * 1000 / `PSEOCP_TICK_US)
`define PSEOCP_CUT_BASE_MS    15
`define PSEOCP_CUT_BASE_TICKS (`PSEOCP_CUT_BASE_MS * 1000 / `PSEOCP_TICK_US)
`define PSEOCP_LIM_BASE_MS    60
`define PSEOCP_LIM_BASE_TICKS (`PSEOCP_LIM_BASE_MS * 1000 / `PSEOCP_TICK_US)

// register offsets
`define PSEOCP_A_POWER   8'h00
`define PSEOCP_A_CUT     8'h04
`define PSEOCP_A_CURVE   8'h08
`define PSEOCP_A_TIMING  8'h0c
`define PSEOCP_A_STATUS  8'h10
`define PSEOCP_A_CLEAR   8'h14
`define PSEOCP_A_IRQ_EN  8'h18
`define PSEOCP_A_GENERAL 8'h1c
`define PSEOCP_A_MA_LO   8'h20
`define PSEOCP_A_MA_HI   8'h24

// field positions
`define PSEOCP_POWER_OFF_LSB 4
`define PSEOCP_CUT_STRIDE    4
`define PSEOCP_TIM_CUT_LSB   0
`define PSEOCP_TIM_LIM_LSB   2
`define PSEOCP_GEN_ALT_BIT   0
`define PSEOCP_GEN_AUTO_BIT  1
`define PSEOCP_ST_CUT_LSB    0
`define PSEOCP_ST_START_LSB  4
`define PSEOCP_ST_LIM_LSB    8

// reset values
`define PSEOCP_CUT_RST    16'h0000
`define PSEOCP_CURVE_RST  4'h0
`define PSEOCP_TIM_RST    4'h0
`define PSEOCP_GEN_RST    2'h2
`define PSEOCP_STAT_RST   12'h000

// classification code that earns the high-power settings
`define PSEOCP_CLASS_HI   3'h4
`define PSEOCP_CUT_CODE_HI 3'h6
`define PSEOCP_CUT_CODE_LO 3'h0

`endif

// ==== logic/pseocp_pkg.sv ====
package pseocp_pkg;

  // sensed port conditions, already synchronised
  typedef struct packed {
    logic over_cut;
    logic at_limit;
    logic power_good;
  } pseocp_sense_type;

  // settings handed to the analog current-limit stage
  typedef struct packed {
    logic       curve_2x;
    logic [2:0] cut_threshold;
    logic       alt_sense_resistor_select;
  } pseocp_cfg_type;

  typedef enum logic [1:0] {ST_OFF, ST_START, ST_ON} pseocp_state_type;

endpackage

// ==== logic/pseocp_port.sv ====
`timescale 1ns/100ps
`default_nettype none

module pseocp_port #(
  parameter int TW = 16
) (
  // clock, reset and timer enables
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       tick,
  input  wire logic                       slow_tick,
  // commands
  input  wire logic                       on_req,
  input  wire logic                       off_req,
  input  wire logic [TW-1:0]              start_len,
  input  wire logic [TW-1:0]              cut_max,
  input  wire logic [TW-1:0]              lim_max,
  input  wire pseocp_pkg::pseocp_sense_type sense,
  // state and events
  output logic                            gate_on,
  output logic                            inrush_mode,
  output logic                            foldback_on,
  output logic                            cut_evt,
  output logic                            start_evt,
  output logic                            lim_evt
);

  pseocp_pkg::pseocp_state_type state_reg;
  pseocp_pkg::pseocp_state_type state_next;
  logic [TW-1:0] start_reg;
  logic [TW-1:0] cut_reg;
  logic [TW-1:0] lim_reg;
  logic          start_end;
  logic          start_fail;
  logic          cut_exp;
  logic          lim_exp;
  logic          in_on;

  // down one per tick while over, up one per slow tick, clamped to max
  function automatic logic [TW-1:0] ud_step(input logic [TW-1:0] cnt,
                                            input logic [TW-1:0] max,
                                            input logic over);
    if (cnt > max)
      ud_step = max;
    else if (over && tick && cnt != '0)
      ud_step = cnt - 1'b1;
    else if (!over && slow_tick && cnt < max)
      ud_step = cnt + 1'b1;
    else
      ud_step = cnt;
  endfunction

  // end of start period and the two expiries
  assign in_on      = (state_reg == pseocp_pkg::ST_ON);
  assign start_end  = (state_reg == pseocp_pkg::ST_START) && tick
                      && (start_reg <= {{(TW-1){1'b0}}, 1'b1});
  assign start_fail = start_end && sense.at_limit;
  assign cut_exp    = in_on && sense.over_cut && tick
                      && (cut_reg <= {{(TW-1){1'b0}}, 1'b1});
  assign lim_exp    = in_on && sense.at_limit && tick
                      && (lim_reg <= {{(TW-1){1'b0}}, 1'b1});

  // next state: any fault or an off command drops the gate
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      pseocp_pkg::ST_OFF:
        if (on_req)
          state_next = pseocp_pkg::ST_START;
      pseocp_pkg::ST_START:
        if (off_req || start_fail)
          state_next = pseocp_pkg::ST_OFF;
        else if (start_end)
          state_next = pseocp_pkg::ST_ON;
      pseocp_pkg::ST_ON:
        if (off_req || cut_exp || lim_exp)
          state_next = pseocp_pkg::ST_OFF;
      default:
        state_next = pseocp_pkg::ST_OFF;
    endcase
  end

  // state and outputs
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg   <= pseocp_pkg::ST_OFF;
      gate_on     <= 1'b0;
      inrush_mode <= 1'b0;
      foldback_on <= 1'b0;
      cut_evt     <= 1'b0;
      start_evt   <= 1'b0;
      lim_evt     <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      gate_on     <= (state_next != pseocp_pkg::ST_OFF);
      inrush_mode <= (state_next == pseocp_pkg::ST_START);
      foldback_on <= (state_next == pseocp_pkg::ST_ON)
                     && sense.power_good;
      cut_evt     <= cut_exp;
      start_evt   <= start_fail;
      lim_evt     <= lim_exp;
    end
  end

  // timers: start counts down once; cut and limit are up/down
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      start_reg <= '0;
      cut_reg   <= '0;
      lim_reg   <= '0;
    end
    else if (state_reg == pseocp_pkg::ST_OFF)
    begin
      start_reg <= start_len;
      cut_reg   <= cut_max;
      lim_reg   <= lim_max;
    end
    else if (state_reg == pseocp_pkg::ST_START)
    begin
      if (tick)
        start_reg <= start_reg - 1'b1;
      cut_reg <= cut_max;
      lim_reg <= lim_max;
    end
    else
    begin
      cut_reg <= ud_step(cut_reg, cut_max, sense.over_cut);
      lim_reg <= ud_step(lim_reg, lim_max, sense.at_limit);
    end
  end

endmodule // pseocp_port

`default_nettype wire

// ==== logic/pseocp_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pseocp_consts.svh"

module pseocp_top #(
  parameter int NP       = 4,
  parameter int TW       = 16,
  parameter int TICK_CYC = `PSEOCP_TICK_CYC
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // register port
  input  wire logic [7:0]                   addr,
  input  wire logic [31:0]                  wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [31:0]                  rdata,
  output logic                              irq,
  // comparator pins, asynchronous
  input  wire logic [NP-1:0]                pin_over_cut,
  input  wire logic [NP-1:0]                pin_at_limit,
  input  wire logic [NP-1:0]                pin_power_good,
  // classification results, same clock
  input  wire logic [NP-1:0][2:0]           class_code,
  // gate and analog controls
  output logic      [NP-1:0]                gate_en,
  output logic      [NP-1:0]                inrush_en,
  output logic      [NP-1:0]                foldback_en,
  output pseocp_pkg::pseocp_cfg_type [NP-1:0] port_cfg
);

  logic [NP-1:0]      gate_w;
  logic [NP-1:0]      inrush_w;
  logic [NP-1:0]      fold_w;
  logic [NP-1:0]      cut_evt_w;
  logic [NP-1:0]      start_evt_w;
  logic [NP-1:0]      lim_evt_w;
  logic [3*NP-1:0]    sync1_reg;
  logic [3*NP-1:0]    sync2_reg;
  logic [NP*4-1:0]    cut_cfg_reg;
  logic [NP*4-1:0]    cut_cfg_next;
  logic [NP-1:0]      curve_reg;
  logic [NP-1:0]      curve_next;
  logic [3:0]         timing_reg;
  logic [1:0]         general_reg;
  logic [3*NP-1:0]    status_reg;
  logic [3*NP-1:0]    irq_en_reg;
  logic [NP-1:0]      on_req_reg;
  logic [NP-1:0]      off_req_reg;
  logic [15:0]        div_reg;
  logic [4:0]         slow_reg;
  logic               tick_reg;
  logic               slow_tick_reg;
  logic [TW-1:0]      cut_max;
  logic [TW-1:0]      lim_max;
  logic [TW-1:0]      start_len;
  logic [3*NP-1:0]    evt_w;
  logic [3*NP-1:0]    clr_w;
  logic [31:0]        rd_mux;
  logic               auto_on;
  logic               wr_power;
  logic               wr_cut;
  logic               wr_curve;
  logic               wr_timing;
  logic               wr_clear;
  logic               wr_irq_en;
  logic               wr_general;
  logic [31:0]        ma_lo;
  logic [31:0]        ma_hi;

  // nominal threshold in mA for a cut code, two codes share 374
  function automatic logic [15:0] cut_ma(input logic [2:0] code);
    unique case (code)
      3'h0, 3'h3: cut_ma = 16'd374;
      3'h1:       cut_ma = 16'd110;
      3'h2:       cut_ma = 16'd204;
      3'h4:       cut_ma = 16'd754;
      3'h5:       cut_ma = 16'd592;
      3'h6:       cut_ma = 16'd645;
      3'h7:       cut_ma = 16'd920;
    endcase
  endfunction

  // timeout in ticks: base doubled per field step
  function automatic logic [TW-1:0] tmo_ticks(input int base,
                                              input logic [1:0] sel);
    tmo_ticks = TW'(base << sel);
  endfunction

  // register decode
  assign wr_power   = wr && (addr == `PSEOCP_A_POWER);
  assign wr_cut     = wr && (addr == `PSEOCP_A_CUT);
  assign wr_curve   = wr && (addr == `PSEOCP_A_CURVE);
  assign wr_timing  = wr && (addr == `PSEOCP_A_TIMING);
  assign wr_clear   = wr && (addr == `PSEOCP_A_CLEAR);
  assign wr_irq_en  = wr && (addr == `PSEOCP_A_IRQ_EN);
  assign wr_general = wr && (addr == `PSEOCP_A_GENERAL);
  assign auto_on    = general_reg[`PSEOCP_GEN_AUTO_BIT];

  // cut and limit timer limits come from the timing field; start length is fixed
  assign cut_max   = tmo_ticks(`PSEOCP_CUT_BASE_TICKS,
                       timing_reg[`PSEOCP_TIM_CUT_LSB +: 2]);
  assign lim_max   = tmo_ticks(`PSEOCP_LIM_BASE_TICKS,
                       timing_reg[`PSEOCP_TIM_LIM_LSB +: 2]);
  assign start_len = TW'(`PSEOCP_START_TICKS);

  // event and clear vectors share the status layout
  assign evt_w = {lim_evt_w, start_evt_w, cut_evt_w};
  assign clr_w = wr_clear ? wdata[3*NP-1:0] : '0;

  // in auto mode a power-on rewrites that port's cut code and curve bit;
  // hardware wins over a host write in the same cycle
  always_comb
  begin
    cut_cfg_next = wr_cut ? wdata[NP*4-1:0] : cut_cfg_reg;
    curve_next   = wr_curve ? wdata[NP-1:0] : curve_reg;
    for (int i = 0; i < NP; i++)
    begin
      if (auto_on && on_req_reg[i])
      begin
        cut_cfg_next[i*`PSEOCP_CUT_STRIDE +: 3] =
          (class_code[i] == `PSEOCP_CLASS_HI) ? `PSEOCP_CUT_CODE_HI
                                              : `PSEOCP_CUT_CODE_LO;
        curve_next[i] = (class_code[i] == `PSEOCP_CLASS_HI);
      end
    end
  end

  // read mux; clear register is write only and reads zero
  always_comb
  begin
    ma_lo = {cut_ma(cut_cfg_reg[`PSEOCP_CUT_STRIDE +: 3]),
             cut_ma(cut_cfg_reg[0 +: 3])};
    ma_hi = {cut_ma(cut_cfg_reg[3*`PSEOCP_CUT_STRIDE +: 3]),
             cut_ma(cut_cfg_reg[2*`PSEOCP_CUT_STRIDE +: 3])};
    unique case (addr)
      `PSEOCP_A_POWER:   rd_mux = 32'(gate_en)
                                  | (32'(inrush_en) << `PSEOCP_POWER_OFF_LSB);
      `PSEOCP_A_CUT:     rd_mux = 32'(cut_cfg_reg);
      `PSEOCP_A_CURVE:   rd_mux = 32'(curve_reg);
      `PSEOCP_A_TIMING:  rd_mux = 32'(timing_reg);
      `PSEOCP_A_STATUS:  rd_mux = 32'(status_reg);
      `PSEOCP_A_IRQ_EN:  rd_mux = 32'(irq_en_reg);
      `PSEOCP_A_GENERAL: rd_mux = 32'(general_reg);
      `PSEOCP_A_MA_LO:   rd_mux = ma_lo;
      `PSEOCP_A_MA_HI:   rd_mux = ma_hi;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // two-flop synchronisers for the comparator pins
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {pin_power_good, pin_at_limit, pin_over_cut};
      sync2_reg <= sync1_reg;
    end
  end

  // tick divider; up-counting runs at one tick in UP_RATIO
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_reg       <= '0;
      slow_reg      <= '0;
      tick_reg      <= 1'b0;
      slow_tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg      <= (div_reg == 16'(TICK_CYC - 1));
      slow_tick_reg <= (div_reg == 16'(TICK_CYC - 1))
                       && (slow_reg == 5'(`PSEOCP_UP_RATIO - 1));
      if (div_reg == 16'(TICK_CYC - 1))
      begin
        div_reg  <= '0;
        slow_reg <= (slow_reg == 5'(`PSEOCP_UP_RATIO - 1)) ? '0
                                                            : slow_reg + 1'b1;
      end
      else
        div_reg <= div_reg + 1'b1;
    end
  end

  // configuration registers and power commands
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cut_cfg_reg <= `PSEOCP_CUT_RST;
      curve_reg   <= `PSEOCP_CURVE_RST;
      timing_reg  <= `PSEOCP_TIM_RST;
      general_reg <= `PSEOCP_GEN_RST;
      irq_en_reg  <= '0;
      on_req_reg  <= '0;
      off_req_reg <= '0;
    end
    else
    begin
      cut_cfg_reg <= cut_cfg_next;
      curve_reg   <= curve_next;
      if (wr_timing)
        timing_reg <= wdata[3:0];
      if (wr_general)
        general_reg <= wdata[1:0];
      if (wr_irq_en)
        irq_en_reg <= wdata[3*NP-1:0];
      on_req_reg  <= wr_power ? wdata[NP-1:0] : '0;
      off_req_reg <= wr_power ? wdata[`PSEOCP_POWER_OFF_LSB +: NP] : '0;
    end
  end

  // sticky faults: set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      status_reg <= `PSEOCP_STAT_RST;
    else
      status_reg <= (status_reg & ~clr_w) | evt_w;
  end

  // bus answer and interrupt level
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata <= 32'h0000_0000;
      irq   <= 1'b0;
    end
    else
    begin
      rdata <= rd ? rd_mux : 32'h0000_0000;
      irq   <= |(((status_reg & ~clr_w) | evt_w) & irq_en_reg);
    end
  end

  // drive outputs; the analog stage sees settings one cycle after
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gate_en     <= '0;
      inrush_en   <= '0;
      foldback_en <= '0;
      port_cfg    <= '0;
    end
    else
    begin
      gate_en     <= gate_w;
      inrush_en   <= inrush_w;
      foldback_en <= fold_w;
      for (int i = 0; i < NP; i++)
      begin
        port_cfg[i].curve_2x      <= curve_reg[i];
        port_cfg[i].cut_threshold <=
          cut_cfg_reg[i*`PSEOCP_CUT_STRIDE +: 3];
        port_cfg[i].alt_sense_resistor_select <=
          general_reg[`PSEOCP_GEN_ALT_BIT];
      end
    end
  end

  // one protection engine per port
  for (genvar g = 0; g < NP; g++)
  begin : g_port
    pseocp_port #(
      .TW (TW)
    ) u_port (
      .clk         (clk),
      .rstn        (rstn),
      .tick        (tick_reg),
      .slow_tick   (slow_tick_reg),
      .on_req      (on_req_reg[g]),
      .off_req     (off_req_reg[g]),
      .start_len   (start_len),
      .cut_max     (cut_max),
      .lim_max     (lim_max),
      .sense       ({sync2_reg[g], sync2_reg[NP+g], sync2_reg[2*NP+g]}),
      .gate_on     (gate_w[g]),
      .inrush_mode (inrush_w[g]),
      .foldback_on (fold_w[g]),
      .cut_evt     (cut_evt_w[g]),
      .start_evt   (start_evt_w[g]),
      .lim_evt     (lim_evt_w[g])
    );
  end

endmodule // pseocp_top

`default_nettype wire

// ==== dv/pseocp_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none

module pseocp_asserts #(
  parameter int NP       = 4,
  parameter int TICK_CYC = 4
) (
  // clock and reset
  input wire logic                              clk,
  input wire logic                              rstn,
  // register port
  input wire logic [7:0]                        addr,
  input wire logic [31:0]                       wdata,
  input wire logic                              wr,
  input wire logic                              rd,
  input wire logic [31:0]                       rdata,
  input wire logic                              irq,
  // port controls
  input wire logic [NP-1:0]                     gate_en,
  input wire logic [NP-1:0]                     inrush_en,
  input wire logic [NP-1:0]                     foldback_en,
  input wire pseocp_pkg::pseocp_cfg_type [NP-1:0] port_cfg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  localparam int START_CYC = 600 * TICK_CYC;
  logic [15:0] inrush_cnt_reg;

  // start period length of port 0; a tick phase of slack either way
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      inrush_cnt_reg <= 16'h0000;
    else if (inrush_en[0])
      inrush_cnt_reg <= inrush_cnt_reg + 16'h0001;
    else
      inrush_cnt_reg <= 16'h0000;

  a_rdata_idle: assert property (
    !$past(rd) |-> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  a_start_max: assert property (
    inrush_cnt_reg <= 16'(START_CYC + TICK_CYC))
    else $error("start period too long");
  a_start_min: assert property (
    $fell(inrush_en[0]) |-> inrush_cnt_reg >= 16'(START_CYC - TICK_CYC))
    else $error("start period ended early");
  a_irq_mask: assert property (
    wr && addr == 8'h18 && wdata[11:0] == 12'h000 |-> ##2 !irq)
    else $error("interrupt high with all events masked");
  a_curve_copy: assert property (
    wr && addr == 8'h08 |-> ##2 port_cfg[0].curve_2x == $past(wdata[0], 2))
    else $error("curve select not handed to clamp");

  // per port relations between gate, start period and foldback
  for (genvar i = 0; i < NP; i++)
  begin : g_port
    a_power_on: assert property (
      wr && addr == 8'h00 && wdata[i] && !wdata[i+4] && !gate_en[i]
      |-> ##[1:3] gate_en[i])
      else $error("power on command not obeyed");
    a_inrush_first: assert property (
      $rose(gate_en[i]) |-> inrush_en[i])
      else $error("port turned on without start period");
    a_inrush_gate: assert property (
      inrush_en[i] |-> gate_en[i])
      else $error("inrush limit on an unpowered port");
    a_fold_after: assert property (
      foldback_en[i] |-> gate_en[i] && !inrush_en[i])
      else $error("foldback active during start or off");
  end

  c_start_fault: cover property ($fell(gate_en[1]));
  c_cut_trip: cover property (gate_en[0] ##1 !gate_en[0]);
  c_irq: cover property ($rose(irq));
endmodule // pseocp_asserts

bind pseocp_top pseocp_asserts #(.NP(NP), .TICK_CYC(TICK_CYC)) i_asserts (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .irq(irq), .gate_en(gate_en), .inrush_en(inrush_en),
  .foldback_en(foldback_en), .port_cfg(port_cfg));

`default_nettype wire

// ==== dv/pseocp_pd_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module pseocp_pd_model (
  // gate side
  input  wire logic [3:0]      gate_en,
  input  wire logic [3:0]      inrush_en,
  input  wire logic [3:0][1:0] load_mode,
  // sensed pins
  output logic      [3:0]      pin_over_cut,
  output logic      [3:0]      pin_at_limit,
  output logic      [3:0]      pin_power_good
);
  // 0 normal, 1 load never charges, 2 overload, 3 clamped short;
  // mode 3 keeps the cut comparator quiet to isolate the limit timer
  for (genvar i = 0; i < 4; i++)
  begin : g_pd
    assign pin_at_limit[i] = gate_en[i] && (load_mode[i] == 2'd1 ||
                             (load_mode[i] == 2'd3 && !inrush_en[i]));
    assign pin_over_cut[i] = gate_en[i] && load_mode[i] == 2'd2;
    assign pin_power_good[i] = gate_en[i] && load_mode[i] != 2'd1;
  end
endmodule // pseocp_pd_model

`default_nettype wire

// ==== dv/test_pseocp.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pseocp_consts.svh"

module test_pseocp;
  localparam int TC = 4;
  logic                       clk;
  logic                       rstn;
  logic                       wr;
  logic                       rd;
  logic                       rd_d = 1'b0;
  logic [7:0]                 addr;
  logic [31:0]                wdata;
  logic [31:0]                d;
  logic [3:0][2:0]            class_code;
  logic [3:0][1:0]            load_mode;
  wire logic [31:0]           rdata;
  wire logic                  irq;
  wire logic [3:0]            over_cut, at_limit, power_good;
  wire logic [3:0]            gate_en, inrush_en, foldback_en;
  pseocp_pkg::pseocp_cfg_type [3:0] port_cfg;
  int                         error_cnt, comparisons, seed;
  logic [31:0]                exp_q[$];
  string                      name_q[$];
  int ma_tab[8] = '{374, 110, 204, 374, 754, 592, 645, 920};
  logic [7:0] ra[8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h30};
  logic [31:0] rv[8] = '{0, 0, 0, 0, 0, 0, 32'h0000_0002, 0};

  pseocp_top #(.NP(4), .TW(16), .TICK_CYC(TC)) i_dut (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .pin_over_cut(over_cut),
    .pin_at_limit(at_limit), .pin_power_good(power_good),
    .class_code(class_code), .gate_en(gate_en), .inrush_en(inrush_en),
    .foldback_en(foldback_en), .port_cfg(port_cfg));

  pseocp_pd_model i_pd (
    .gate_en(gate_en), .inrush_en(inrush_en), .load_mode(load_mode),
    .pin_over_cut(over_cut), .pin_at_limit(at_limit),
    .pin_power_good(power_good));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input string n, input logic [31:0] seen,
                       input logic [31:0] expv);
    comparisons++;
    if (seen !== expv)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, expv, seen);
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // the note is queued before the strobe so the watcher always finds it
  task automatic bus_rd(input string n, input logic [7:0] a,
                        input logic [31:0] e);
    exp_q.push_back(e);
    name_q.push_back(n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n * TC) @(posedge clk);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    rd_d <= rd;
    if (rd_d && exp_q.size() > 0)
      check(name_q.pop_front(), rdata, exp_q.pop_front());
  end

  initial
  begin
    #(40 * 20000);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    seed = 29;
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    load_mode = '0;
    class_code = {3'h4, 3'h1, 3'h1, 3'h1};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 8; k++)
      bus_rd("reset", ra[k], rv[k]);
    bus_wr(`PSEOCP_A_GENERAL, 32'h0000_0001);
    // the general bit reaches port_cfg one edge after the register
    repeat (2) @(posedge clk);
    check("alt", 32'(port_cfg[3].alt_sense_resistor_select), 1);
    repeat (4)
    begin
      d = $random(seed);
      bus_wr(`PSEOCP_A_CUT, d);
      bus_rd("cut", `PSEOCP_A_CUT, d & 32'h0000_ffff);
      bus_wr(`PSEOCP_A_TIMING, d);
      bus_rd("timing", `PSEOCP_A_TIMING, d & 32'h0000_000f);
    end
    // every cut code, curve bit set to match as the host must
    for (int c = 0; c < 8; c++)
    begin
      bus_wr(`PSEOCP_A_CUT, {16'h0000, {4{1'b0, 3'(c)}}});
      bus_wr(`PSEOCP_A_CURVE, (c > 3) ? 32'h0000_000f : 0);
      bus_rd("ma", `PSEOCP_A_MA_LO, {2{16'(ma_tab[c])}});
    end
    bus_wr(`PSEOCP_A_CUT, 32'h0000_0000);
    bus_wr(`PSEOCP_A_TIMING, 32'h0000_0000);
    bus_wr(`PSEOCP_A_CURVE, 32'h0000_0000);
    bus_wr(`PSEOCP_A_IRQ_EN, 32'h0000_0fff);
    load_mode <= {2'd0, 2'd3, 2'd1, 2'd0};
    bus_wr(`PSEOCP_A_POWER, 32'h0000_0007);
    ticks(2);
    bus_rd("power", `PSEOCP_A_POWER, 32'h0000_0077);
    ticks(605);
    bus_rd("power", `PSEOCP_A_POWER, 32'h0000_0005);
    bus_rd("status", `PSEOCP_A_STATUS, 32'h0000_0020);
    check("irq", 32'(irq), 1);
    check("fold", 32'(foldback_en), 32'h0000_0005);
    bus_wr(`PSEOCP_A_IRQ_EN, 32'h0000_0000);
    bus_rd("status", `PSEOCP_A_STATUS, 32'h0000_0020);
    check("irq", 32'(irq), 0);
    bus_wr(`PSEOCP_A_CLEAR, 32'h0000_0020);
    bus_wr(`PSEOCP_A_IRQ_EN, 32'h0000_0fff);
    bus_rd("status", `PSEOCP_A_STATUS, 32'h0000_0000);
    check("irq", 32'(irq), 0);
    // port 2 clamps from the end of its start period
    ticks(570);
    bus_rd("power", `PSEOCP_A_POWER, 32'h0000_0005);
    ticks(40);
    bus_rd("power", `PSEOCP_A_POWER, 32'h0000_0001);
    bus_rd("status", `PSEOCP_A_STATUS, 32'h0000_0400);
    bus_wr(`PSEOCP_A_CLEAR, 32'h0000_0400);
    // overload, partial recovery at the slow rate, overload again
    load_mode[0] <= 2'd2;
    ticks(100);
    load_mode[0] <= 2'd0;
    ticks(320);
    load_mode[0] <= 2'd2;
    ticks(60);
    bus_rd("power", `PSEOCP_A_POWER, 32'h0000_0001);
    ticks(30);
    bus_rd("power", `PSEOCP_A_POWER, 32'h0000_0000);
    bus_rd("status", `PSEOCP_A_STATUS, 32'h0000_0001);
    check("irq", 32'(irq), 1);
    bus_wr(`PSEOCP_A_CLEAR, 32'h0000_0fff);
    bus_wr(`PSEOCP_A_CUT, 32'h0000_1111);
    bus_wr(`PSEOCP_A_CURVE, 32'h0000_0001);
    bus_wr(`PSEOCP_A_GENERAL, 32'h0000_0002);
    bus_wr(`PSEOCP_A_POWER, 32'h0000_0008);
    bus_rd("cut", `PSEOCP_A_CUT, 32'h0000_6111);
    bus_rd("curve", `PSEOCP_A_CURVE, 32'h0000_0009);
    check("cfg3", 32'(port_cfg[3].cut_threshold), 6);
    bus_wr(`PSEOCP_A_POWER, 32'h0000_00f0);
    ticks(1);
    bus_rd("power", `PSEOCP_A_POWER, 32'h0000_0000);
    repeat (2) @(posedge clk);
    wrap_up();
  end
endmodule // test_pseocp

`default_nettype wire
